//--- hdl/frps_ctrl.v
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// Functional notes
// - Software must reissue any program or erase that a pulse cut short.
// - No read until the post-reset read delay has passed.
// - Probe line high-voltage qualifier is driven from the control register.
// - Init high-voltage qualifier with ordinary bus cycles for protect work.
// - Enter with a three-cycle sequence, leave with a four-cycle sequence.
`include "frps_defines.vh"

module frps_ctrl #(
  parameter AW = 22,
  parameter DW = 16
) (
  // Clock and reset.
  input  wire          clk_sys,
  input  wire          rst_b,
  // Avalon-MM slave.
  input  wire [2:0]    avs_address,
  input  wire          avs_read,
  input  wire          avs_write,
  input  wire [31:0]   avs_writedata,
  output reg  [31:0]   avs_readdata,
  output wire          avs_waitrequest,
  // Flash pins.
  output reg  [AW-1:0] flash_addr,
  output reg  [DW-1:0] flash_dq_out,
  output reg           flash_dq_oe,
  input  wire [DW-1:0] flash_dq_in,
  output reg           flash_ce_n,
  output reg           flash_oe_n,
  output reg           flash_we_n,
  output reg           device_init_n,
  output wire          device_init_hv,
  output wire          id_probe_hv,
  output wire          boot_guard_accel_pin,
  output wire          boot_guard_accel_hv,
  input  wire          op_done_flag
);

  // One-hot sequencer states.
  localparam S_IDLE  = 7'h01;
  localparam S_RSTLO = 7'h02;
  localparam S_RSTBY = 7'h04;
  localparam S_RSTRH = 7'h08;
  localparam S_RD    = 7'h10;
  localparam S_WRLO  = 7'h20;
  localparam S_WRHI  = 7'h40;

  reg  [6:0]    state;
  reg  [15:0]   cnt;
  reg  [3:0]    ctrl;
  reg  [AW-1:0] addr_reg;
  reg  [DW-1:0] wdata_reg;
  reg  [DW-1:0] rdata;
  reg  [2:0]    seq_cmd;
  reg  [2:0]    seq_idx;
  reg  [2:0]    seq_len;
  reg           secure;
  reg           readable;
  reg           ack;
  reg  [AW-1:0] cyc_addr;
  reg  [DW-1:0] cyc_data;

  wire          busy    = ~state[0];
  wire          req     = avs_read | avs_write;
  wire          sel_cmd = avs_write & (avs_address == `FRPS_REG_CMD);
  wire          stall   = sel_cmd & busy;
  wire          take    = req & ack & ~stall;
  wire [2:0]    new_cmd = avs_writedata[2:0];

  // Commands wait while the sequencer is busy; other accesses take two edges.
  assign avs_waitrequest = req & (~ack | stall);

  // High-voltage qualifiers; the reset pulse masks the init one, the security region the accelerator one, the probe one is unmasked.
  assign device_init_hv       = ctrl[`FRPS_CTRL_INIT_HV] & device_init_n;
  assign id_probe_hv          = ctrl[`FRPS_CTRL_PROBE_HV];
  assign boot_guard_accel_pin = ctrl[`FRPS_CTRL_GUARD];
  assign boot_guard_accel_hv  = ctrl[`FRPS_CTRL_ACCEL] & ~secure;

  // Address and data of the current write cycle, by sequence step.
  always @* begin
    cyc_addr = addr_reg;
    cyc_data = wdata_reg;
    if (seq_cmd == `FRPS_CMD_ENTER || seq_cmd == `FRPS_CMD_EXIT) begin
      case (seq_idx)
        3'h0: begin
          cyc_addr = `FRPS_UNLK_A1;
          cyc_data = `FRPS_UNLK_D1;
        end
        3'h1: begin
          cyc_addr = `FRPS_UNLK_A2;
          cyc_data = `FRPS_UNLK_D2;
        end
        3'h2: begin
          cyc_addr = `FRPS_UNLK_A1;
          cyc_data = (seq_cmd == `FRPS_CMD_ENTER) ? `FRPS_ENTER_D : `FRPS_EXIT_D3;
        end
        default: begin
          cyc_addr = {AW{1'b0}};
          cyc_data = `FRPS_EXIT_D4;
        end
      endcase
    end
  end

  // Bus handshake and register file.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h00000000;
      ctrl         <= `FRPS_CTRL_RESET;
      addr_reg     <= {AW{1'b0}};
      wdata_reg    <= {DW{1'b0}};
    end else begin
      ack <= req & ~take;
      if (req && !ack) begin
        case (avs_address)
          `FRPS_REG_CTRL:   avs_readdata <= {28'h0000000, ctrl};
          `FRPS_REG_ADDR:   avs_readdata <= {{(32-AW){1'b0}}, addr_reg};
          `FRPS_REG_WDATA:  avs_readdata <= {{(32-DW){1'b0}}, wdata_reg};
          `FRPS_REG_STATUS: avs_readdata <= {28'h0000000, readable, secure,
                                             op_done_flag, busy};
          `FRPS_REG_RDATA:  avs_readdata <= {{(32-DW){1'b0}}, rdata};
          default:          avs_readdata <= 32'h00000000;
        endcase
      end
      if (take && avs_write) begin
        case (avs_address)
          `FRPS_REG_CTRL:  ctrl <= avs_writedata[3:0];
          `FRPS_REG_ADDR:  addr_reg <= avs_writedata[AW-1:0];
          `FRPS_REG_WDATA: wdata_reg <= avs_writedata[DW-1:0];
          default: ;
        endcase
      end
    end
  end

  // Pin sequencer.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state         <= S_IDLE;
      cnt           <= 16'h0000;
      seq_cmd       <= 3'h0;
      seq_idx       <= 3'h0;
      seq_len       <= 3'h0;
      secure        <= 1'b0;
      readable      <= 1'b1;
      rdata         <= {DW{1'b0}};
      flash_addr    <= {AW{1'b0}};
      flash_dq_out  <= {DW{1'b0}};
      flash_dq_oe   <= 1'b0;
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      device_init_n <= 1'b1;
    end else begin
      case (state)
        S_IDLE: begin
          cnt <= 16'h0000;
          if (take && sel_cmd) begin
            seq_cmd <= new_cmd;
            seq_idx <= 3'h0;
            case (new_cmd)
              `FRPS_CMD_PULSE: begin
                state         <= S_RSTLO;
                device_init_n <= 1'b0;
                readable      <= 1'b0;
              end
              `FRPS_CMD_READ: begin
                state      <= S_RD;
                flash_addr <= addr_reg;
                flash_ce_n <= 1'b0;
                flash_oe_n <= 1'b0;
              end
              // The flash itself refuses writes to protected or locked sectors.
              `FRPS_CMD_WRITE, `FRPS_CMD_ENTER, `FRPS_CMD_EXIT: begin
                state   <= S_WRLO;
                seq_len <= (new_cmd == `FRPS_CMD_ENTER) ? `FRPS_ENTER_LEN :
                           (new_cmd == `FRPS_CMD_EXIT) ? `FRPS_EXIT_LEN : 3'h1;
              end
              default: ;
            endcase
          end
        end
        S_RSTLO: begin
          cnt <= cnt + 16'h0001;
          if (cnt + 16'h0001 >= `FRPS_RP_CYC) begin
            state         <= S_RSTBY;
            cnt           <= 16'h0000;
            device_init_n <= 1'b1;
            secure        <= 1'b0;
          end
        end
        S_RSTBY: begin
          // Busy flag holds us; once ready the settle time still runs.
          if (!op_done_flag) begin
            cnt <= 16'h0000;
          end else begin
            cnt <= cnt + 16'h0001;
            if (cnt + 16'h0001 >= `FRPS_READY_CYC) begin
              state <= S_RSTRH;
              cnt   <= 16'h0000;
            end
          end
        end
        S_RSTRH: begin
          cnt <= cnt + 16'h0001;
          if (cnt + 16'h0001 >= `FRPS_RH_CYC) begin
            state    <= S_IDLE;
            cnt      <= 16'h0000;
            readable <= 1'b1;
          end
        end
        S_RD: begin
          cnt <= cnt + 16'h0001;
          if (cnt + 16'h0001 >= `FRPS_ACC_CYC) begin
            rdata      <= flash_dq_in;
            state      <= S_IDLE;
            cnt        <= 16'h0000;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
          end
        end
        S_WRLO: begin
          // Output gate stays high whenever the data bus is driven.
          flash_addr   <= cyc_addr;
          flash_dq_out <= cyc_data;
          flash_dq_oe  <= 1'b1;
          flash_ce_n   <= 1'b0;
          flash_we_n   <= 1'b0;
          cnt          <= cnt + 16'h0001;
          if (cnt + 16'h0001 >= `FRPS_WP_CYC + 1) begin
            state      <= S_WRHI;
            cnt        <= 16'h0000;
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
          end
        end
        S_WRHI: begin
          cnt <= cnt + 16'h0001;
          if (cnt + 16'h0001 >= `FRPS_WPH_CYC) begin
            cnt         <= 16'h0000;
            flash_dq_oe <= 1'b0;
            if (seq_idx + 3'h1 >= seq_len) begin
              state <= S_IDLE;
              if (seq_cmd == `FRPS_CMD_ENTER) begin
                secure <= 1'b1;
              end else if (seq_cmd == `FRPS_CMD_EXIT) begin
                secure <= 1'b0;
              end
            end else begin
              seq_idx <= seq_idx + 3'h1;
              state   <= S_WRLO;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

//--- hdl/frps_defines.vh
`ifndef FRPS_DEFINES_VH
`define FRPS_DEFINES_VH

// Clock period of clk_sys in nanoseconds.
`define FRPS_CLK_NS        100

// Flash pin timing in nanoseconds.
`define FRPS_T_RP_NS       500
`define FRPS_T_READY_NS    20000
`define FRPS_T_RH_NS       50
`define FRPS_T_ACC_NS      100
`define FRPS_T_WP_NS       100
`define FRPS_T_WPH_NS      100

// Cycle counts; least times round up.
`define FRPS_RP_CYC    ((`FRPS_T_RP_NS    + `FRPS_CLK_NS - 1) / `FRPS_CLK_NS)
`define FRPS_READY_CYC ((`FRPS_T_READY_NS + `FRPS_CLK_NS - 1) / `FRPS_CLK_NS)
`define FRPS_RH_CYC    ((`FRPS_T_RH_NS    + `FRPS_CLK_NS - 1) / `FRPS_CLK_NS)
`define FRPS_ACC_CYC   ((`FRPS_T_ACC_NS   + `FRPS_CLK_NS - 1) / `FRPS_CLK_NS)
`define FRPS_WP_CYC    ((`FRPS_T_WP_NS    + `FRPS_CLK_NS - 1) / `FRPS_CLK_NS)
`define FRPS_WPH_CYC   ((`FRPS_T_WPH_NS   + `FRPS_CLK_NS - 1) / `FRPS_CLK_NS)

// Register word indices on the Avalon slave.
`define FRPS_REG_CTRL      3'h0
`define FRPS_REG_ADDR      3'h1
`define FRPS_REG_WDATA     3'h2
`define FRPS_REG_CMD       3'h3
`define FRPS_REG_STATUS    3'h4
`define FRPS_REG_RDATA     3'h5

// Control register bit positions and reset value.
`define FRPS_CTRL_GUARD    0
`define FRPS_CTRL_ACCEL    1
`define FRPS_CTRL_INIT_HV  2
`define FRPS_CTRL_PROBE_HV 3
`define FRPS_CTRL_RESET    4'h1

// Status register bit positions.
`define FRPS_ST_BUSY       0
`define FRPS_ST_DONE       1
`define FRPS_ST_SECURE     2
`define FRPS_ST_READABLE   3

// Command codes written to the command register.
`define FRPS_CMD_READ      3'h1
`define FRPS_CMD_WRITE     3'h2
`define FRPS_CMD_ENTER     3'h3
`define FRPS_CMD_EXIT      3'h4
`define FRPS_CMD_PULSE     3'h5

// Unlock cycle addresses and data of the security region sequences, and their lengths.
`define FRPS_UNLK_A1       22'h000555
`define FRPS_UNLK_A2       22'h0002AA
`define FRPS_UNLK_D1       16'h00AA
`define FRPS_UNLK_D2       16'h0055
`define FRPS_ENTER_D       16'h0088
`define FRPS_EXIT_D3       16'h0090
`define FRPS_EXIT_D4       16'h0000
`define FRPS_ENTER_LEN     3'h3
`define FRPS_EXIT_LEN      3'h4

`endif

//--- bench/frps_flash_model.sv
`timescale 1ns/1ns
module frps_flash_model (
  // Clock for the idle bus pattern.
  input  wire        clk_sys,
  // Flash pins.
  input  wire [21:0] flash_addr,
  input  wire [15:0] flash_dq_out,
  input  wire        flash_ce_n,
  input  wire        flash_oe_n,
  input  wire        flash_we_n,
  input  wire        device_init_n,
  output wire [15:0] flash_dq_in,
  output reg         op_done_flag
);
  reg       secure = 1'b0;
  reg [1:0] step   = 2'h0;
  reg       junk   = 1'b0;
  wire      in_sec = secure && (flash_addr < 22'h8);

  // A released bus shows a pattern that flips every cycle, never the last value.
  always @(posedge clk_sys) junk <= ~junk;
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n && device_init_n) ?
    (in_sec ? (16'h0080 | flash_addr[15:0]) : (flash_addr[15:0] ^ 16'h5A5A)) :
    {8{junk, ~junk}};

  // Reset pulse drops the mapping and holds the flag busy until it settles.
  initial op_done_flag = 1'b1;
  always @(device_init_n) begin
    if (!device_init_n) begin
      secure = 1'b0;
      step = 2'h0;
      op_done_flag = 1'b0;
    end else
      op_done_flag = #2000 1'b1;
  end

  // Unlock cycles are decoded as the write strobe rises; writes during a pulse are ignored.
  always @(posedge flash_we_n) begin
    if (device_init_n) begin
      if (flash_addr == 22'h555 && flash_dq_out == 16'hAA) step = 2'h1;
      else if (step == 2'h1 && flash_addr == 22'h2AA && flash_dq_out == 16'h55) step = 2'h2;
      else if (step == 2'h2 && flash_dq_out == 16'h88) begin
        secure = 1'b1;
        step = 2'h0;
      end else if (step == 2'h2 && flash_dq_out == 16'h90) step = 2'h3;
      else if (step == 2'h3 && flash_dq_out == 16'h0) begin
        secure = 1'b0;
        step = 2'h0;
      end else step = 2'h0;
    end
  end
endmodule

//--- bench/frps_ctrl_checker.sv
`timescale 1ns/1ns
module frps_ctrl_checker #(
  parameter AW = 22,
  parameter DW = 16
) (
  // Clock, reset and bus handshake.
  input wire          clk_sys,
  input wire          rst_b,
  input wire          avs_read,
  input wire          avs_waitrequest,
  // Flash pins.
  input wire [AW-1:0] flash_addr,
  input wire [DW-1:0] flash_dq_out,
  input wire          flash_dq_oe,
  input wire          flash_ce_n,
  input wire          flash_oe_n,
  input wire          flash_we_n,
  input wire          device_init_n,
  input wire          device_init_hv
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_init_pulse_len: assert property ($fell(device_init_n) |-> !device_init_n [*5])
    else $error("init pulse shorter than five cycles");
  a_init_no_strobe: assert property (!device_init_n |->
    flash_ce_n && flash_oe_n && flash_we_n && !flash_dq_oe)
    else $error("strobe active during init pulse");
  a_drive_gate: assert property (flash_dq_oe |-> flash_oe_n)
    else $error("data driven while output enabled");
  a_read_no_write: assert property (!flash_oe_n |-> flash_we_n && !flash_ce_n)
    else $error("read strobe without select or with write");
  a_read_delay: assert property ($rose(device_init_n) |-> flash_oe_n [*8])
    else $error("read too soon after init pulse");
  a_init_hv_qual: assert property (device_init_hv |-> device_init_n)
    else $error("high voltage qualifier with init low");
  a_write_hold: assert property ($fell(flash_we_n) |-> !flash_ce_n && flash_dq_oe
    ##1 flash_we_n && flash_dq_oe && $stable(flash_addr) && $stable(flash_dq_out))
    else $error("write cycle shape wrong");
  a_bus_answer: assert property ($rose(avs_read) |-> ##1 !avs_waitrequest)
    else $error("register read not answered");
endmodule

bind frps_ctrl frps_ctrl_checker #(.AW(AW), .DW(DW)) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .avs_read(avs_read), .avs_waitrequest(avs_waitrequest),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .device_init_n(device_init_n), .device_init_hv(device_init_hv));

//--- bench/frps_ctrl_tb.sv
`timescale 1ns/1ns
module frps_ctrl_tb;
  reg         clk_sys = 1'b0;
  reg         rst_b = 1'b0;
  reg  [2:0]  avs_address = 3'h0;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [31:0] q;
  wire [31:0] avs_readdata;
  wire [21:0] flash_addr;
  wire [15:0] flash_dq_out, flash_dq_in;
  wire        avs_waitrequest, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, device_init_n;
  wire        device_init_hv, id_probe_hv, boot_guard_accel_pin, boot_guard_accel_hv, op_done_flag;
  integer     n_errors = 0, n_checks = 0, cyc = 0;

  always #50 clk_sys = ~clk_sys;

  frps_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .device_init_n(device_init_n), .device_init_hv(device_init_hv), .id_probe_hv(id_probe_hv),
    .boot_guard_accel_pin(boot_guard_accel_pin), .boot_guard_accel_hv(boot_guard_accel_hv),
    .op_done_flag(op_done_flag));

  frps_flash_model u_flash (.clk_sys(clk_sys), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .device_init_n(device_init_n), .flash_dq_in(flash_dq_in),
    .op_done_flag(op_done_flag));

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // One register access; the request holds until waitrequest is sampled low at a rising edge.
  task bus(input wr, input [2:0] a, input [31:0] d);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
    end
  endtask

  // Polls status until the sequencer is idle.
  task idle;
    begin
      bus(0, 3'h4, 0);
      while (q[0] !== 1'b0) bus(0, 3'h4, 0);
    end
  endtask

  task cmd(input [2:0] c);
    begin
      bus(1, 3'h3, {29'h0, c});
      idle;
    end
  endtask

  task fread(input [21:0] a);
    begin
      bus(1, 3'h1, {10'h0, a});
      cmd(3'h1);
      bus(0, 3'h5, 0);
    end
  endtask

  // A hang counts as a mismatch and closes the run.
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      end_sim;
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    bus(0, 3'h0, 0);
    chk(q, 32'h1);
    chk(boot_guard_accel_pin, 1'b1);
    bus(1, 3'h7, 32'hF);
    bus(0, 3'h6, 0);
    chk(q, 32'h0);
    bus(0, 3'h0, 0);
    chk(q, 32'h1);
    $display("test reset values done");
    bus(1, 3'h0, 32'hE);
    chk({device_init_hv, id_probe_hv}, 2'h3);
    chk({boot_guard_accel_pin, boot_guard_accel_hv}, 2'h1);
    $display("test qualifiers done");
    cmd(3'h3);
    chk(boot_guard_accel_hv, 1'b0);
    bus(0, 3'h4, 0);
    chk(q[2], 1'b1);
    fread(22'h3);
    chk(q, 32'h83);
    bus(1, 3'h3, 32'h5);
    bus(0, 3'h4, 0);
    chk(q[1:0], 2'b01);
    idle;
    chk(q[3:2], 2'b10);
    fread(22'h3);
    chk(q, 32'h5A59);
    $display("test reset pulse done");
    cmd(3'h3);
    cmd(3'h4);
    bus(0, 3'h4, 0);
    chk(q[2], 1'b0);
    chk(boot_guard_accel_hv, 1'b1);
    fread(22'h3);
    chk(q, 32'h5A59);
    $display("test exit sequence done");
    end_sim;
  end
endmodule
